//--- hdl/async_fifo_bitbang_port.sv
// Device-side parallel port: async byte FIFO and bit-bang modes
// Functional notes
// - Async FIFO transfers run only when configuration memory selects it.
// - FIFO transfers trigger on falling read or write strobe edges.
// - Outside bit-bang mode the data bus is an input, driven only for a read until its synchronised rise.
// - rx_data_avail_n is low only while a receive byte is available.
// - After a read rises, rx_data_avail_n goes high, low again if more.
// - Both status outputs float during reset so the pull-ups read high.
// - tx_space_avail_n is low only while the transmit FIFO has room.
// - A falling read strobe puts the current receive byte on the bus.
// - A read strobe rise pops the receive FIFO and fetches the next byte.
// - A falling write strobe stores the bus byte into the transmit FIFO.
// - A send/wake low pulse when suspended with wakeup on asks resume.
// - A send/wake low pulse while powered flushes data at next bulk IN.
// - Bit-bang mode makes the eight lines a host-controlled parallel bus.
// - Each bit-bang pin update pulses pin_update_pulse_n low.
// - Each bit-bang sample is marked by a rising pin_sample_pulse_n.
`timescale 1ns/100ps
`default_nettype none
module async_fifo_bitbang_port (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Mode selection and power state
  input wire fifo_port_pkg::port_cfg_t cfg,
  input wire logic power_enable_n,
  // External strobes
  input wire logic rdStrobe_n,
  input wire logic wrStrobe_n,
  input wire logic send_now_wake_n,
  // Parallel data bus, split into pin signals
  input wire logic [fifo_port_pkg::DATA_W-1:0] busIn,
  output logic [fifo_port_pkg::DATA_W-1:0] busOut,
  output logic [fifo_port_pkg::DATA_W-1:0] busOe,
  // FIFO status pins with their output enables
  output logic rx_data_avail_n,
  output logic rxAvailOe,
  output logic tx_space_avail_n,
  output logic txSpaceOe,
  // Bit-bang strobe pins
  output logic pin_update_pulse_n,
  output logic pin_sample_pulse_n,
  // USB side: bytes towards the external party
  input wire logic rxInValid,
  input wire logic [fifo_port_pkg::DATA_W-1:0] rxInData,
  output logic rxInReady,
  // USB side: bytes from the external party
  output logic txOutValid,
  output logic [fifo_port_pkg::DATA_W-1:0] txOutData,
  input wire logic txOutReady,
  // USB side: bit-bang commands and samples
  input wire logic bbWrValid,
  input wire fifo_port_pkg::bb_cmd_t bbCmd,
  input wire logic bbSampleReq,
  output logic bbSampleValid,
  output logic [fifo_port_pkg::DATA_W-1:0] bbSampleData,
  // USB side: send-now and resume requests
  output logic sendNowReq,
  output logic resumeReq
);

  localparam int DW = fifo_port_pkg::DATA_W;

  // Synchronised strobes and their previous values
  logic [fifo_port_pkg::STROBE_W-1:0] strobeSync;
  logic [fifo_port_pkg::STROBE_W-1:0] strobePrev;
  // Bus samples delayed to line up with the synchronised strobes
  logic [DW-1:0] busDly [fifo_port_pkg::EDGE_LATENCY];
  fifo_port_pkg::rd_state_t rdState;
  fifo_port_pkg::rd_state_t next_rdState;
  logic sampleArmed;

  // Buffer handshakes
  logic rxOutValid;
  logic [DW-1:0] rxOutData;
  logic txInReady;

  signal_sync u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .asyncIn({send_now_wake_n, wrStrobe_n, rdStrobe_n}),
    .syncOut(strobeSync)
  );

  // Mode decode
  // FIFO mode gate
  wire fifoActive = cfg.asyncFifoSel && !cfg.bitBangEn;
  wire bbActive = cfg.bitBangEn;

  // Edge detection on the second synchroniser stage only
  wire rdSync = strobeSync[fifo_port_pkg::STB_RD];
  wire wrSync = strobeSync[fifo_port_pkg::STB_WR];
  wire wakeSync = strobeSync[fifo_port_pkg::STB_WAKE];
  wire rdFall = strobePrev[fifo_port_pkg::STB_RD] && !rdSync;
  wire rdRise = !strobePrev[fifo_port_pkg::STB_RD] && rdSync;
  wire wrFall = strobePrev[fifo_port_pkg::STB_WR] && !wrSync;
  wire wakeFall = strobePrev[fifo_port_pkg::STB_WAKE] && !wakeSync;

  // Read and write acceptance
  // ignore reads without data
  wire rdAccept = fifoActive && rdFall && (rdState == fifo_port_pkg::RD_IDLE)
    && !rx_data_avail_n;
  wire rxPop = fifoActive && rdRise && (rdState == fifo_port_pkg::RD_DRIVE);
  wire txPush = fifoActive && wrFall && !tx_space_avail_n;
  wire [DW-1:0] busAtEdge = busDly[fifo_port_pkg::EDGE_LATENCY-1];

  // Status next values
  // high after read rise
  wire rxHold = (rdState == fifo_port_pkg::RD_IDLE)
    || ((rdState == fifo_port_pkg::RD_DRIVE) && !rdRise);
  wire next_rxAvail_n = !(fifoActive && rxOutValid && rxHold);
  wire next_txSpace_n = !(fifoActive && txInReady && !txPush);

  // Receive path buffer: a stalled reader back-pressures the USB side
  two_entry_buffer u_rxBuf (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .inValid(rxInValid),
    .inData(rxInData),
    .inReady(rxInReady),
    .outValid(rxOutValid),
    .outData(rxOutData),
    .outReady(rxPop)
  );

  // Transmit path buffer: a stalled USB side holds tx_space_avail_n high
  two_entry_buffer u_txBuf (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .inValid(txPush),
    .inData(busAtEdge),
    .inReady(txInReady),
    .outValid(txOutValid),
    .outData(txOutData),
    .outReady(txOutReady)
  );

  // Read sequencer; the gap state lets the buffer settle after a pop
  always_comb begin
    next_rdState = rdState;
    unique case (rdState)
      fifo_port_pkg::RD_IDLE: begin
        if (rdAccept) begin
          next_rdState = fifo_port_pkg::RD_DRIVE;
        end
      end
      fifo_port_pkg::RD_DRIVE: begin
        if (rdRise || !fifoActive) begin
          next_rdState = fifo_port_pkg::RD_GAP;
        end
      end
      fifo_port_pkg::RD_GAP: begin
        next_rdState = fifo_port_pkg::RD_IDLE;
      end
    endcase
  end

  // Edge history, bus alignment and sequencer state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      strobePrev <= fifo_port_pkg::STROBE_IDLE;
      busDly <= '{default: fifo_port_pkg::DATA_RESET};
      rdState <= fifo_port_pkg::RD_IDLE;
    end else begin
      strobePrev <= strobeSync;
      busDly[0] <= busIn;
      for (int k = 1; k < fifo_port_pkg::EDGE_LATENCY; k++) begin
        busDly[k] <= busDly[k-1];
      end
      rdState <= next_rdState;
    end
  end

  // Status pins: floating in reset, pull-ups make them read inactive
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rxAvailOe <= 1'h0;
      txSpaceOe <= 1'h0;
      rx_data_avail_n <= 1'h1;
      tx_space_avail_n <= 1'h1;
    end else begin
      rxAvailOe <= 1'h1;
      txSpaceOe <= 1'h1;
      rx_data_avail_n <= next_rxAvail_n;
      tx_space_avail_n <= next_txSpace_n;
    end
  end

  // Data bus drive; the release follows the pin by the sync latency
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busOut <= fifo_port_pkg::DATA_RESET;
      busOe <= fifo_port_pkg::BUS_ALL_IN;
    end else if (bbActive) begin
      if (bbWrValid) begin
        busOut <= bbCmd.data;
        busOe <= bbCmd.dir;
      end
    end else if (rdAccept) begin
      busOut <= rxOutData;
      busOe <= fifo_port_pkg::BUS_ALL_OUT;
    end else if (!fifoActive || rdState != fifo_port_pkg::RD_DRIVE
        || rdRise) begin
      busOe <= fifo_port_pkg::BUS_ALL_IN;
    end
  end

  // Bit-bang strobes and sampling
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_update_pulse_n <= 1'h1;
      pin_sample_pulse_n <= 1'h1;
      sampleArmed <= 1'h0;
      bbSampleValid <= 1'h0;
      bbSampleData <= fifo_port_pkg::DATA_RESET;
    end else begin
      pin_update_pulse_n <= !(bbActive && bbWrValid);
      sampleArmed <= bbActive && bbSampleReq && !sampleArmed;
      pin_sample_pulse_n <= !(bbActive && bbSampleReq && !sampleArmed);
      bbSampleValid <= sampleArmed;
      if (sampleArmed) begin
        bbSampleData <= busIn;
      end
    end
  end

  // Send-now and resume requests, one-cycle pulses to the USB engine
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sendNowReq <= 1'h0;
      resumeReq <= 1'h0;
    end else begin
      resumeReq <= wakeFall && power_enable_n && cfg.remoteWakeEn;
      sendNowReq <= wakeFall && !power_enable_n;
    end
  end

  // Checks on the port's own behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  fifo_mode_only_a: assert property (
    !cfg.asyncFifoSel |=> rx_data_avail_n && tx_space_avail_n)
    else $error("status pins active outside FIFO mode");

  read_drive_end_a: assert property (
    fifoActive && !bbActive && rdRise |=> busOe == fifo_port_pkg::BUS_ALL_IN)
    else $error("bus still driven after read strobe rose");

  avail_has_byte_a: assert property (
    !rx_data_avail_n |-> rxOutValid)
    else $error("receive available shown with empty buffer");

  avail_after_read_a: assert property (
    rxPop |=> rx_data_avail_n [*2])
    else $error("receive available not raised after read");

  reset_float_a: assert property (
    @(posedge core_clk) disable iff (1'h0)
    sys_rst |=> !rxAvailOe && !txSpaceOe && rx_data_avail_n)
    else $error("status pins driven during reset");

  space_has_room_a: assert property (
    !tx_space_avail_n |-> txInReady && $past(fifoActive))
    else $error("transmit space shown while buffer full");

  read_byte_out_a: assert property (
    rdAccept |=> busOe == fifo_port_pkg::BUS_ALL_OUT
      && busOut == $past(rxOutData))
    else $error("read did not place receive byte on bus");

  pop_on_rise_a: assert property (
    fifoActive && rdRise && rdState == fifo_port_pkg::RD_DRIVE
      |=> rdState == fifo_port_pkg::RD_GAP
      ##1 rdState == fifo_port_pkg::RD_IDLE)
    else $error("read rise did not complete the read");

  write_capture_a: assert property (
    fifoActive && wrFall && !tx_space_avail_n
      |-> txPush && busAtEdge == $past(busIn, 2))
    else $error("write fall did not capture aligned bus byte");

  wake_resume_a: assert property (
    wakeFall && power_enable_n && cfg.remoteWakeEn
      |=> resumeReq && !sendNowReq)
    else $error("wake pulse did not request resume");

  send_now_a: assert property (
    wakeFall && !power_enable_n |=> sendNowReq && !resumeReq)
    else $error("send pulse did not request flush");

  update_pulse_a: assert property (
    bbActive && bbWrValid
      |=> !pin_update_pulse_n && busOut == $past(bbCmd.data))
    else $error("pin update not strobed");

  sample_edge_a: assert property (
    bbActive && bbSampleReq && !sampleArmed
      |=> !pin_sample_pulse_n ##1 pin_sample_pulse_n && bbSampleValid)
    else $error("sample strobe did not rise with sample");

endmodule : async_fifo_bitbang_port
`default_nettype wire

//--- hdl/signal_sync.sv
// Two-flop synchroniser bank for the asynchronous strobe inputs
`timescale 1ns/100ps
`default_nettype none
module signal_sync #(
  parameter int WIDTH = fifo_port_pkg::STROBE_W,
  parameter logic [WIDTH-1:0] IDLE = fifo_port_pkg::STROBE_IDLE
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Asynchronous inputs and their synchronised copies
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  // First stage feeds only the second stage of the same bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta;
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          meta <= IDLE[i];
          syncOut[i] <= IDLE[i];
        end else begin
          meta <= asyncIn[i];
          syncOut[i] <= meta;
        end
      end
    end
  endgenerate

endmodule : signal_sync
`default_nettype wire

//--- hdl/two_entry_buffer.sv
// Small valid/ready FIFO with registered ready and valid flags
`timescale 1ns/100ps
`default_nettype none
module two_entry_buffer #(
  parameter int WIDTH = fifo_port_pkg::DATA_W,
  parameter int DEPTH = fifo_port_pkg::BUF_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Filling side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Draining side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [CW-1:0] count;

  // Handshakes and next occupancy; ready and valid leave straight from flops
  wire full = !inReady;
  wire empty = !outValid;
  wire push = inValid && !full;
  wire pop = outReady && !empty;
  wire [CW-1:0] next_count = count + CW'(push) - CW'(pop);
  assign outData = mem[rdPtr];

  // Storage is not reset; the flags alone say what is valid
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  // Pointers and flags; flags are registered so ready has no input path
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      inReady <= 1'h1;
      outValid <= 1'h0;
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == LAST) ? '0 : wrPtr + PW'(1);
      end
      if (pop) begin
        rdPtr <= (rdPtr == LAST) ? '0 : rdPtr + PW'(1);
      end
      count <= next_count;
      inReady <= (next_count != CW'(DEPTH));
      outValid <= (next_count != '0);
    end
  end

endmodule : two_entry_buffer
`default_nettype wire

//--- shared/fifo_port_pkg.sv
// Shared constants and carrier types for the parallel FIFO / bit-bang port
`default_nettype none
package fifo_port_pkg;

  // Data path geometry
  localparam int DATA_W = 8;
  localparam int BUF_DEPTH = 2;
  localparam int SYNC_STAGES = 2;

  // Strobe inputs crossing into core_clk: read, write, send-now/wake
  localparam int STROBE_W = 3;
  localparam int STB_RD = 0;
  localparam int STB_WR = 1;
  localparam int STB_WAKE = 2;
  // Strobes idle high, so the synchroniser starts from all ones
  localparam logic [STROBE_W-1:0] STROBE_IDLE = 3'h7;

  // Bus drive patterns and values after reset
  localparam logic [DATA_W-1:0] BUS_ALL_OUT = 8'hff;
  localparam logic [DATA_W-1:0] BUS_ALL_IN = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  // Cycles from a pin edge to its detection in core_clk
  localparam int EDGE_LATENCY = SYNC_STAGES;

  // Configuration-memory and host mode selection
  typedef struct packed {
    logic asyncFifoSel;  // Configuration memory selects async FIFO mode
    logic bitBangEn;     // Host software selects bit-bang mode
    logic remoteWakeEn;  // Configuration memory enables remote wakeup
  } port_cfg_t;

  // Host command that sets the bit-bang pins
  typedef struct packed {
    logic [DATA_W-1:0] dir;   // One bit per line, high drives the line
    logic [DATA_W-1:0] data;
  } bb_cmd_t;

  // Read-side sequencer
  typedef enum logic [1:0] {
    RD_IDLE,
    RD_DRIVE,
    RD_GAP
  } rd_state_t;

endpackage : fifo_port_pkg
`default_nettype wire

//--- testbench/async_fifo_bitbang_port_tb.sv
// Self-checking bench for the parallel FIFO / bit-bang port
`timescale 1ns/100ps
`default_nettype none
module async_fifo_bitbang_port_tb;
  localparam int W = fifo_port_pkg::DATA_W;
  logic core_clk, sys_rst, power_enable_n;
  fifo_port_pkg::port_cfg_t cfg;
  logic rdStrobe_n, wrStrobe_n, send_now_wake_n;
  logic [W-1:0] busIn, busOut, busOe, prevOe, b, d;
  logic rx_data_avail_n, rxAvailOe, tx_space_avail_n, txSpaceOe;
  logic pin_update_pulse_n, pin_sample_pulse_n, rxInValid, rxInReady;
  logic [W-1:0] rxInData, txOutData, bbSampleData;
  logic txOutValid, txOutReady, bbWrValid, bbSampleReq, bbSampleValid;
  fifo_port_pkg::bb_cmd_t bbCmd;
  logic sendNowReq, resumeReq;
  logic [W-1:0] txExp[$], rdExp[$], bbExp[$];
  int err_total, check_count, seed, sendCnt, wakeCnt, n, s0, w0;

  async_fifo_bitbang_port dut (.core_clk, .sys_rst, .cfg, .power_enable_n,
    .rdStrobe_n, .wrStrobe_n, .send_now_wake_n, .busIn, .busOut, .busOe,
    .rx_data_avail_n, .rxAvailOe, .tx_space_avail_n, .txSpaceOe,
    .pin_update_pulse_n, .pin_sample_pulse_n, .rxInValid, .rxInData,
    .rxInReady, .txOutValid, .txOutData, .txOutReady, .bbWrValid, .bbCmd,
    .bbSampleReq, .bbSampleValid, .bbSampleData, .sendNowReq, .resumeReq);

  ext_ctrl_model host (.core_clk, .busOut, .busOe, .rx_data_avail_n,
    .tx_space_avail_n, .rdStrobe_n, .wrStrobe_n, .send_now_wake_n, .busIn);

  // Clock at 40 MHz
  always #12.5 core_clk = ~core_clk;

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  // Results are scored against the oldest note when they appear
  always @(posedge core_clk) begin
    prevOe <= busOe;
    sendCnt <= sendCnt + int'(sendNowReq === 1'h1);
    wakeCnt <= wakeCnt + int'(resumeReq === 1'h1);
    if (txOutValid === 1'h1 && txOutReady === 1'h1) begin
      if (txExp.size() == 0) chk("tx extra", 1, 0);
      else chk("tx byte", txOutData, txExp.pop_front());
    end
    if (!sys_rst && !cfg.bitBangEn && busOe !== 8'h00
        && prevOe === 8'h00) begin
      if (rdExp.size() == 0) chk("rd extra", busOe, 0);
      else chk("rd byte", busOut, rdExp.pop_front());
      chk("rd oe", busOe, fifo_port_pkg::BUS_ALL_OUT);
    end
    if (bbSampleValid === 1'h1) begin
      if (bbExp.size() == 0) chk("bb extra", 1, 0);
      else chk("bb sample", bbSampleData, bbExp.pop_front());
    end
  end

  // Hang guard sized well beyond the full sequence
  initial begin
    #600000;
    err_total++;
    close_out();
  end

  initial begin
    seed = 25017;
    {err_total, check_count, sendCnt, wakeCnt} = '0;
    core_clk = 1'h0;
    sys_rst = 1'h1;
    cfg = 3'h4;
    power_enable_n = 1'h0;
    {rxInValid, txOutReady, bbWrValid, bbSampleReq} = '0;
    rxInData = '0;
    bbCmd = '0;
    prevOe = '0;
    repeat (15) @(posedge core_clk);
    @(negedge core_clk) chk("rst oe", {rxAvailOe, txSpaceOe}, 0);
    chk("rst bus", busOe, 0);
    @(posedge core_clk) sys_rst <= 1'h0;
    repeat (3) @(negedge core_clk);
    chk("stat idle", {rxAvailOe, txSpaceOe, rx_data_avail_n}, 7);
    chk("tx room", tx_space_avail_n, 0);
    // two writes fill the stalled buffer, a third is refused
    repeat (2) begin
      b = $random(seed);
      txExp.push_back(b);
      host.writeByte(b, 1'h1);
    end
    repeat (3) @(negedge core_clk);
    chk("tx full", tx_space_avail_n, 1);
    host.writeByte(8'h3c, 1'h0);
    n = 0;
    while (txExp.size() > 0 && n < 200) begin
      @(posedge core_clk) txOutReady <= $random(seed);
      n++;
    end
    @(posedge core_clk) txOutReady <= 1'h1;
    repeat (8) @(negedge core_clk);
    chk("tx left", txExp.size(), 0);
    chk("tx room back", tx_space_avail_n, 0);
    // Load receive bytes until the buffer refuses
    repeat (4) begin
      @(negedge core_clk);
      if (rxInReady === 1'h1) begin
        b = $random(seed);
        rdExp.push_back(b);
        @(posedge core_clk) rxInValid <= 1'h1;
        rxInData <= b;
        @(posedge core_clk) rxInValid <= 1'h0;
      end
    end
    @(negedge core_clk) chk("rx avail", rx_data_avail_n, 0);
    // a read outside FIFO mode is ignored
    @(posedge core_clk) cfg.asyncFifoSel <= 1'h0;
    host.readByte(1'h0);
    repeat (6) @(posedge core_clk);
    cfg.asyncFifoSel <= 1'h1;
    // reads drain in order, status drops after each
    n = 0;
    while (rdExp.size() > 0 && n < 8) begin
      host.readByte(1'h1);
      // Status stays high for two edges after the rise is seen
      repeat (4) @(posedge core_clk);
      @(negedge core_clk) chk("rx after rd", rx_data_avail_n, 1);
      n++;
    end
    chk("rx left", rdExp.size(), 0);
    // a read with nothing offered drives nothing
    host.readByte(1'h0);
    @(negedge core_clk) chk("rd idle bus", busOe, 0);
    // bit-bang writes set drive and value with a pulse
    @(posedge core_clk) cfg.bitBangEn <= 1'h1;
    for (int i = 0; i < 3; i++) begin
      b = $random(seed);
      d = (i == 2) ? 8'h00 : $random(seed);
      @(posedge core_clk) bbWrValid <= 1'h1;
      bbCmd <= {d, b};
      @(posedge core_clk) bbWrValid <= 1'h0;
      @(negedge core_clk) chk("bb oe", busOe, d);
      chk("bb out", busOut & d, b & d);
      chk("bb upd", pin_update_pulse_n, 0);
      @(negedge core_clk) chk("bb upd end", pin_update_pulse_n, 1);
    end
    // samples of the lines each marked by a strobe rise
    repeat (2) begin
      b = $random(seed);
      host.putPins(1'h1, b);
      repeat (2) @(posedge core_clk);
      bbSampleReq <= 1'h1;
      bbExp.push_back(b);
      @(posedge core_clk) bbSampleReq <= 1'h0;
      @(negedge core_clk) chk("smp low", pin_sample_pulse_n, 0);
      @(negedge core_clk) chk("smp rise", pin_sample_pulse_n, 1);
    end
    host.putPins(1'h0, 8'h00);
    @(negedge core_clk) chk("bb left", bbExp.size(), 0);
    // send-now when powered, resume only when asleep with wakeup
    @(posedge core_clk) cfg.bitBangEn <= 1'h0;
    for (int k = 0; k < 3; k++) begin
      s0 = sendCnt;
      w0 = wakeCnt;
      @(posedge core_clk) power_enable_n <= (k != 0);
      cfg.remoteWakeEn <= (k == 1);
      host.wake();
      chk("send now", 16'(sendCnt - s0), 16'(k == 0));
      chk("resume", 16'(wakeCnt - w0), 16'(k == 1));
    end
    close_out();
  end
endmodule : async_fifo_bitbang_port_tb
`default_nettype wire

//--- testbench/ext_ctrl_model.sv
// Model of the external controller that works the port's pins
`timescale 1ns/100ps
`default_nettype none
module ext_ctrl_model #(
  parameter int W = fifo_port_pkg::DATA_W
) (
  // Clock
  input wire logic core_clk,
  // Pins driven by the device
  input wire logic [W-1:0] busOut,
  input wire logic [W-1:0] busOe,
  input wire logic rx_data_avail_n,
  input wire logic tx_space_avail_n,
  // Pins driven by this controller
  output logic rdStrobe_n,
  output logic wrStrobe_n,
  output logic send_now_wake_n,
  output logic [W-1:0] busIn
);
  logic hostDrv;
  logic [W-1:0] hostVal;
  logic [W-1:0] floatPat;

  initial begin
    rdStrobe_n = 1'h1;
    wrStrobe_n = 1'h1;
    send_now_wake_n = 1'h1;
    hostDrv = 1'h0;
    hostVal = '0;
    floatPat = 8'h5a;
  end

  // Undriven lines toggle so a stale value never passes as data
  always @(posedge core_clk) floatPat <= ~floatPat;

  // wire level from both parties' drivers
  assign busIn = (busOe & busOut) | (~busOe & (hostDrv ? hostVal : floatPat));

  // read only while a byte is offered, unless told to misbehave
  task automatic readByte(input bit waitAvail);
    int n;
    n = 0;
    while (waitAvail && rx_data_avail_n !== 1'h0 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    @(posedge core_clk);
    rdStrobe_n <= 1'h0;
    repeat (6) @(posedge core_clk);
    rdStrobe_n <= 1'h1;
  endtask : readByte

  // write only with room, strobe low then high, data held around it
  task automatic writeByte(input logic [W-1:0] b, input bit waitRoom);
    int n;
    n = 0;
    while (waitRoom && tx_space_avail_n !== 1'h0 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    @(posedge core_clk);
    hostDrv <= 1'h1;
    hostVal <= b;
    @(posedge core_clk);
    wrStrobe_n <= 1'h0;
    repeat (4) @(posedge core_clk);
    wrStrobe_n <= 1'h1;
    repeat (3) @(posedge core_clk);
    hostDrv <= 1'h0;
    repeat (3) @(posedge core_clk);
  endtask : writeByte

  // Drive or release the lines in bit-bang input use
  task automatic putPins(input bit en, input logic [W-1:0] v);
    @(posedge core_clk);
    hostDrv <= en;
    hostVal <= v;
  endtask : putPins

  // Low pulse on the send/wake input, then idle high again
  task automatic wake();
    @(posedge core_clk);
    send_now_wake_n <= 1'h0;
    repeat (4) @(posedge core_clk);
    send_now_wake_n <= 1'h1;
    repeat (12) @(posedge core_clk);
  endtask : wake
endmodule : ext_ctrl_model
`default_nettype wire
